// ===== verilog/bpp_consts.svh
// Register indices, field positions, reset values and pin constants for the port B/E mux
`ifndef BPP_CONSTS_SVH
`define BPP_CONSTS_SVH

// Register indices; byte address is four times the index
`define BPP_IDX_PB_DATA 10'h001
`define BPP_IDX_PB_DIR 10'h003
`define BPP_IDX_PE_DATA 10'h008
`define BPP_IDX_PE_DIR 10'h009
`define BPP_IDX_PE_ASSIGN 10'h00A

// Function assignment register bit positions
`define BPP_FA_INV_E 0
`define BPP_FA_CAL 1
`define BPP_FA_RDWR 2
`define BPP_FA_STROBE 3
`define BPP_FA_NO_ECLK 4
`define BPP_FA_PIPE 5
`define BPP_FA_CLK_TEST 6
`define BPP_FA_NO_DBE 7

// Function assignment reset values per mode
`define BPP_FA_RST_NORM_EXP 8'h00
`define BPP_FA_RST_SPEC 8'h2C
`define BPP_FA_RST_PERIPH 8'hD0
`define BPP_FA_RST_NORM_SINGLE 8'h90

// Bits that follow write-once / anytime-except-first / anytime policy
`define BPP_FA_ONCE_MASK 8'hAD
`define BPP_FA_CLK_TEST_MASK 8'h40
`define BPP_FA_NO_ECLK_MASK 8'h10
`define BPP_FA_CAL_MASK 8'h02

// Port E direction bits that may be stored; pins 1 and 0 are input only
`define BPP_PE_DIR_MASK 8'hFC
// Port E pins that carry a pull-up
`define BPP_PE_PULL_MASK 8'h8F

// Pin and bus constants
`define BPP_BYTE_ZERO 8'h00
`define BPP_OE_NONE 8'hFF
`define BPP_WORD_ZERO 32'h0000_0000

`endif

// ===== verilog/bpp_pkg.sv
// Types shared by the port B/E pin mux
package bpp_pkg;

    typedef enum logic [2:0] {
        BPP_NORM_SINGLE = 3'h0,
        BPP_NORM_EXP_NARROW = 3'h1,
        BPP_NORM_EXP_WIDE = 3'h2,
        BPP_SPEC_SINGLE = 3'h3,
        BPP_SPEC_EXP_NARROW = 3'h4,
        BPP_SPEC_EXP_WIDE = 3'h5,
        BPP_PERIPH = 3'h6
    } bpp_mode_t;

    // Bus-control sources from the core that port E may carry
    typedef struct packed {
        logic e_clock;
        logic data_bus_enable_out;
        logic low_byte_strobe;
        logic read_write;
        logic pipe_status_hi;
        logic pipe_status_lo;
        logic clock_test;
        logic calibration;
    } bpp_alt_t;

    // Low byte of the multiplexed external bus from the core
    typedef struct packed {
        logic [7:0] addr_lo;
        logic [7:0] wdata_lo;
        logic addr_phase;
        logic data_drive;
    } bpp_ext_t;

    typedef struct packed {
        logic init_done;
        logic fa_written;
        logic [7:0] pb_latch;
        logic [7:0] pb_dir;
        logic [7:0] pe_latch;
        logic [7:0] pe_dir;
        logic [7:0] fa;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] pb_out;
        logic [7:0] pb_oe_n;
        logic [7:0] pe_out;
        logic [7:0] pe_oe_n;
        logic [7:0] pe_pull;
        logic [7:0] ext_rdata_lo;
        logic irq_level;
        logic nmi_level;
        logic e_clock_in;
    } bpp_state_t;

endpackage : bpp_pkg

// ===== verilog/bpp_port_mux.sv
// Port B and port E pin logic with APB register access
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "bpp_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Expanded modes: port B carries low address, plus data in wide modes
// - Single-chip: port B is GPIO by direction
// - Port B registers absent in expanded/peripheral
// - Direction 0 input, 1 output
// - PE1/PE0 input only, readable, direction reads zero
// - Port E registers absent periph or emulated in expanded
// - One pull-up bit, input pins only
// - Alternate function overrides direction bit
// - Assignment register reset depends on mode
// - Special expanded: bus controls active from reset
// - Peripheral: assignment hidden, clock test set
// - No-data-enable write policy and PE7 choice
// - Clock test bit policy and PE6 output
// - Pipe status enable policy and PE6/PE5
// - No-E-clock bit write policy by mode
// - E clock input in peripheral, else output
// - PE4 E clock unless bit set or single-chip stretch
// - Port E registers accessible unless periph or emulated in expanded, dir reset zero
// - Strobe enable drives PE3 outside excluded modes
// - Read/write enable drives PE2 outside single-chip
// - Inverted-E select picks PE7 signal
module bpp_port_mux
    import bpp_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode and controls held outside this block
    input wire bpp_mode_t mode,
    input wire logic emulate_port_e,
    input wire logic e_stretch_mode,
    input wire logic pull_up_port_e,
    // Core side of the external bus and bus controls
    input wire bpp_ext_t ext_bus,
    input wire bpp_alt_t alt_src,
    output logic [7:0] ext_rdata_lo,
    output logic e_clock_in,
    output logic irq_level,
    output logic nonmaskable_irq_in,
    // Port B pins
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_n,
    // Port E pins
    input wire logic [7:0] pe_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe_n,
    output logic [7:0] pe_pull_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Mode helpers

    function automatic logic is_expanded(input bpp_mode_t m);
        is_expanded = (m == BPP_NORM_EXP_NARROW) || (m == BPP_NORM_EXP_WIDE) ||
                      (m == BPP_SPEC_EXP_NARROW) || (m == BPP_SPEC_EXP_WIDE);
    endfunction : is_expanded

    function automatic logic is_single(input bpp_mode_t m);
        is_single = (m == BPP_NORM_SINGLE) || (m == BPP_SPEC_SINGLE);
    endfunction : is_single

    function automatic logic is_special(input bpp_mode_t m);
        is_special = (m == BPP_SPEC_SINGLE) || (m == BPP_SPEC_EXP_NARROW) ||
                     (m == BPP_SPEC_EXP_WIDE);
    endfunction : is_special

    function automatic logic [7:0] fa_reset(input bpp_mode_t m);
        case (m)
            BPP_NORM_SINGLE: fa_reset = `BPP_FA_RST_NORM_SINGLE;
            BPP_PERIPH: fa_reset = `BPP_FA_RST_PERIPH;
            BPP_SPEC_SINGLE,
            BPP_SPEC_EXP_NARROW,
            BPP_SPEC_EXP_WIDE: fa_reset = `BPP_FA_RST_SPEC;
            default: fa_reset = `BPP_FA_RST_NORM_EXP;
        endcase
    endfunction : fa_reset

    // Bits of the assignment register that the next write may change
    function automatic logic [7:0] fa_write_mask(input bpp_mode_t m, input logic written);
        logic [7:0] msk;
        msk = `BPP_FA_CAL_MASK;
        if (is_special(m)) begin
            if (written) begin
                msk = msk | `BPP_FA_ONCE_MASK | `BPP_FA_CLK_TEST_MASK;
            end
        end else if (!written) begin
            msk = msk | `BPP_FA_ONCE_MASK;
        end
        if (m == BPP_SPEC_SINGLE) begin
            msk = msk | `BPP_FA_NO_ECLK_MASK;
        end else if ((m == BPP_NORM_SINGLE) && !written) begin
            msk = msk | `BPP_FA_NO_ECLK_MASK;
        end
        fa_write_mask = msk;
    endfunction : fa_write_mask

    // Pin level for inputs, latch for outputs
    function automatic logic [7:0] gpio_read(input logic [7:0] pins, input logic [7:0] latch,
                                             input logic [7:0] dir);
        gpio_read = (pins & ~dir) | (latch & dir);
    endfunction : gpio_read

    ////////////////////////////////////////////////////////////////////////////
    // State

    bpp_state_t r_ff;
    bpp_state_t nxt_r;

    logic [7:0] fa_eff;
    logic [9:0] idx;
    logic pb_present;
    logic pe_present;
    logic fa_present;
    logic hit;
    logic [7:0] rd_byte;
    logic [7:0] wmask;
    logic [7:0] alt_oe;
    logic [7:0] alt_val;
    logic [7:0] pe_gpio_dir;
    logic single_m;
    logic exp_m;
    logic periph_m;

    always_comb begin
        nxt_r = r_ff;
        single_m = is_single(mode);
        exp_m = is_expanded(mode);
        periph_m = (mode == BPP_PERIPH);

        // Mode reset value is caught on the first enabled edge after release
        fa_eff = r_ff.init_done ? r_ff.fa : fa_reset(mode);
        if (!r_ff.init_done) begin
            nxt_r.init_done = 1'b1;
            nxt_r.fa = fa_reset(mode);
        end

        ////////////////////////////////////////////////////////////////////////
        // Register decode

        pb_present = single_m;
        pe_present = !periph_m && !(exp_m && emulate_port_e);
        fa_present = !periph_m;
        idx = paddr[11:2];
        hit = 1'b0;
        rd_byte = `BPP_BYTE_ZERO;
        if (paddr[1:0] == 2'h0) begin
            case (idx)
                `BPP_IDX_PB_DATA: begin
                    hit = pb_present;
                    rd_byte = gpio_read(pb_in, r_ff.pb_latch, r_ff.pb_dir);
                end
                `BPP_IDX_PB_DIR: begin
                    hit = pb_present;
                    rd_byte = r_ff.pb_dir;
                end
                `BPP_IDX_PE_DATA: begin
                    hit = pe_present;
                    rd_byte = gpio_read(pe_in, r_ff.pe_latch, pe_gpio_dir);
                end
                `BPP_IDX_PE_DIR: begin
                    hit = pe_present;
                    rd_byte = r_ff.pe_dir & `BPP_PE_DIR_MASK;
                end
                `BPP_IDX_PE_ASSIGN: begin
                    hit = fa_present;
                    rd_byte = fa_eff;
                end
                default: begin
                    hit = 1'b0;
                    rd_byte = `BPP_BYTE_ZERO;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // APB: one wait cycle, then pready; writes land on the pready edge

        nxt_r.pready = psel && penable && !r_ff.pready;
        nxt_r.pslverr = 1'b0;
        nxt_r.prdata = `BPP_WORD_ZERO;
        if (psel && penable && !r_ff.pready) begin
            nxt_r.pslverr = !hit;
            nxt_r.prdata = (pwrite || !hit) ? `BPP_WORD_ZERO : {24'h00_0000, rd_byte};
        end
        wmask = fa_write_mask(mode, r_ff.fa_written);
        if (psel && penable && r_ff.pready && pwrite && hit) begin
            case (idx)
                `BPP_IDX_PB_DATA: nxt_r.pb_latch = pwdata[7:0];
                `BPP_IDX_PB_DIR: nxt_r.pb_dir = pwdata[7:0];
                `BPP_IDX_PE_DATA: nxt_r.pe_latch = pwdata[7:0];
                `BPP_IDX_PE_DIR: nxt_r.pe_dir = pwdata[7:0] & `BPP_PE_DIR_MASK;
                `BPP_IDX_PE_ASSIGN: begin
                    nxt_r.fa = (fa_eff & ~wmask) | (pwdata[7:0] & wmask);
                    nxt_r.fa_written = 1'b1;
                end
                default: nxt_r.fa_written = r_ff.fa_written;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Port E alternate functions

        alt_oe = `BPP_BYTE_ZERO;
        alt_val = `BPP_BYTE_ZERO;
        // PE7: data enable or inverted E in expanded, else calibration when enabled
        if (exp_m && !fa_eff[`BPP_FA_NO_DBE]) begin
            alt_oe[7] = 1'b1;
            alt_val[7] = fa_eff[`BPP_FA_INV_E] ? !alt_src.e_clock :
                         alt_src.data_bus_enable_out;
        end else if (fa_eff[`BPP_FA_CAL]) begin
            alt_oe[7] = 1'b1;
            alt_val[7] = alt_src.calibration;
        end
        // PE6: pipe status wins over the clock test output
        if (exp_m && fa_eff[`BPP_FA_PIPE]) begin
            alt_oe[6] = 1'b1;
            alt_val[6] = alt_src.pipe_status_hi;
        end else if (fa_eff[`BPP_FA_CLK_TEST] && !single_m &&
                     !(exp_m && !is_special(mode))) begin
            alt_oe[6] = 1'b1;
            alt_val[6] = alt_src.clock_test;
        end
        if (exp_m && fa_eff[`BPP_FA_PIPE]) begin
            alt_oe[5] = 1'b1;
            alt_val[5] = alt_src.pipe_status_lo;
        end
        // PE4: E clock; a peripheral-mode E is taken in, never driven
        if (periph_m) begin
            alt_oe[4] = 1'b1;
            alt_val[4] = 1'b0;
        end else if (!fa_eff[`BPP_FA_NO_ECLK] && !(single_m && e_stretch_mode)) begin
            alt_oe[4] = 1'b1;
            alt_val[4] = alt_src.e_clock;
        end
        if (fa_eff[`BPP_FA_STROBE] && !single_m && (mode != BPP_NORM_EXP_NARROW)) begin
            alt_oe[3] = 1'b1;
            alt_val[3] = alt_src.low_byte_strobe;
        end
        if (fa_eff[`BPP_FA_RDWR] && !single_m) begin
            alt_oe[2] = 1'b1;
            alt_val[2] = alt_src.read_write;
        end

        // Direction bits matter only where no alternate function owns the pin
        pe_gpio_dir = r_ff.pe_dir & `BPP_PE_DIR_MASK & ~alt_oe;
        nxt_r.pe_out = (alt_val & alt_oe) | (r_ff.pe_latch & pe_gpio_dir);
        nxt_r.pe_oe_n = ~((alt_oe & ~{3'h0, periph_m, 4'h0}) | pe_gpio_dir);
        nxt_r.pe_pull = pull_up_port_e ? (`BPP_PE_PULL_MASK & nxt_r.pe_oe_n) :
                        `BPP_BYTE_ZERO;
        nxt_r.irq_level = pe_in[1];
        nxt_r.nmi_level = pe_in[0];
        nxt_r.e_clock_in = periph_m ? pe_in[4] : 1'b0;

        ////////////////////////////////////////////////////////////////////////
        // Port B: bus byte in expanded and peripheral, GPIO in single chip

        nxt_r.ext_rdata_lo = pb_in;
        if (single_m) begin
            nxt_r.pb_out = r_ff.pb_latch;
            nxt_r.pb_oe_n = ~r_ff.pb_dir;
        end else if (mode == BPP_NORM_EXP_NARROW || mode == BPP_SPEC_EXP_NARROW) begin
            nxt_r.pb_out = ext_bus.addr_lo;
            nxt_r.pb_oe_n = `BPP_BYTE_ZERO;
        end else begin
            nxt_r.pb_out = ext_bus.addr_phase ? ext_bus.addr_lo : ext_bus.wdata_lo;
            nxt_r.pb_oe_n = (ext_bus.addr_phase || ext_bus.data_drive) ?
                            `BPP_BYTE_ZERO : `BPP_OE_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register stage; outputs settle one cycle behind their sources

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '0;
            r_ff.pb_oe_n <= `BPP_OE_NONE;
            r_ff.pe_oe_n <= `BPP_OE_NONE;
        end else if (clk_en) begin
            r_ff <= nxt_r;
        end
    end

    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign pb_out = r_ff.pb_out;
    assign pb_oe_n = r_ff.pb_oe_n;
    assign pe_out = r_ff.pe_out;
    assign pe_oe_n = r_ff.pe_oe_n;
    assign pe_pull_en = r_ff.pe_pull;
    assign ext_rdata_lo = r_ff.ext_rdata_lo;
    assign e_clock_in = r_ff.e_clock_in;
    assign irq_level = r_ff.irq_level;
    assign nonmaskable_irq_in = r_ff.nmi_level;

endmodule : bpp_port_mux

// ===== verif/bpp_ext_partner.sv
// Far-side model: external devices and pull-ups resolving port B/E pin levels
`timescale 1ns/1ps
module bpp_ext_partner (
    // Clock
    input wire logic pclk,
    // Device side of the pins, port B above port E
    input wire logic [15:0] dev_out,
    input wire logic [15:0] dev_oe_n,
    input wire logic [15:0] pull_en,
    // What the external devices drive
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    // Resolved pin levels
    output logic [15:0] pin
);
    logic [15:0] last_ff = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // A floating pin shows the inverse of its last level, so a stale value never passes
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!dev_oe_n[i]) begin
                pin[i] = dev_out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pull_en[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = ~last_ff[i];
            end
        end
    end

    always_ff @(posedge pclk) begin
        last_ff <= pin;
    end
endmodule : bpp_ext_partner

// ===== verif/bpp_port_mux_checker.sv
// Concurrent checks on the port B/E pin mux ports
`timescale 1ns/1ps
`include "bpp_consts.svh"
module bpp_port_mux_checker
    import bpp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB answer
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Mode and controls
    input wire bpp_mode_t mode,
    input wire logic emulate_port_e,
    input wire logic e_stretch_mode,
    input wire logic pull_up_port_e,
    // Pins
    input wire bpp_ext_t ext_bus,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pe_in,
    input wire logic [7:0] pe_oe_n,
    input wire logic [7:0] pe_pull_en,
    input wire logic e_clock_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic sc;
    logic [9:0] idx;
    assign sc = (mode == BPP_NORM_SINGLE) || (mode == BPP_SPEC_SINGLE);
    assign idx = paddr[11:2];

    // Pin ownership straight after reset, from the mode reset of the assignment register
    function automatic logic [7:0] rst_oe(input bpp_mode_t m, input logic es);
        case (m)
            BPP_NORM_SINGLE: rst_oe = 8'hFF;
            BPP_SPEC_SINGLE: rst_oe = es ? 8'hFF : 8'hEF;
            BPP_NORM_EXP_NARROW, BPP_NORM_EXP_WIDE: rst_oe = 8'h6F;
            BPP_PERIPH: rst_oe = 8'hBF;
            default: rst_oe = 8'h03;
        endcase
    endfunction : rst_oe

    ////////////////////////////////////////////////////////////////////////////////
    AST_IRQ_PINS_INPUT: assert property (pe_oe_n[1:0] == 2'b11)
        else $error("interrupt pins driven");
    AST_NARROW_ADDR: assert property (clk_en && mode inside {1, 4}
        |=> pb_oe_n == 8'h00 && pb_out == $past(ext_bus.addr_lo))
        else $error("port B lost the address byte");
    AST_WIDE_DATA: assert property (clk_en && mode inside {2, 5, 6} &&
        ext_bus.data_drive && !ext_bus.addr_phase
        |=> pb_oe_n == 8'h00 && pb_out == $past(ext_bus.wdata_lo))
        else $error("port B lost the data byte");
    AST_PB_ABSENT: assert property (pready && !sc &&
        idx inside {`BPP_IDX_PB_DATA, `BPP_IDX_PB_DIR} |-> pslverr)
        else $error("port B register served off chip");
    AST_PE_ABSENT: assert property (pready && (mode == BPP_PERIPH || !sc && emulate_port_e)
        && idx inside {`BPP_IDX_PE_DATA, `BPP_IDX_PE_DIR} |-> pslverr)
        else $error("port E register served while hidden");
    AST_PERIPH_ECLK_IN: assert property (clk_en && mode == BPP_PERIPH
        |=> pe_oe_n[4] && e_clock_in == $past(pe_in[4]))
        else $error("E clock pin not an input");
    AST_PULL_INPUTS: assert property ($past(clk_en) && $past(presetn) |->
        pe_pull_en == ($past(pull_up_port_e) ? (pe_oe_n & `BPP_PE_PULL_MASK) : 8'h00))
        else $error("pull-up on a driven or unlisted pin");
    AST_RESET_PINS: assert property ($rose(presetn) && clk_en
        |=> pe_oe_n == rst_oe(mode, e_stretch_mode))
        else $error("port E ownership wrong after reset");
endmodule : bpp_port_mux_checker

bind bpp_port_mux bpp_port_mux_checker u_chk (.pclk, .presetn, .clk_en, .paddr, .pready,
    .pslverr, .mode, .emulate_port_e, .e_stretch_mode, .pull_up_port_e, .ext_bus, .pb_out,
    .pb_oe_n, .pe_in, .pe_oe_n, .pe_pull_en, .e_clock_in);

// ===== verif/tb_bus_port_pin_assignment.sv
// Testbench for the port B/E pin mux
`timescale 1ns/1ps
`include "bpp_consts.svh"
module tb_bus_port_pin_assignment import bpp_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    bpp_mode_t mode = BPP_NORM_SINGLE;
    logic emulate_port_e = 1'b0;
    logic e_stretch_mode = 1'b0;
    logic pull_up_port_e = 1'b0;
    bpp_ext_t ext_bus = '0;
    bpp_alt_t alt_src = 8'hD6;
    logic [15:0] ext_en = 16'h0000;
    logic [15:0] ext_val = 16'h0000;
    wire logic [15:0] pins;
    logic [31:0] prdata;
    logic pready, pslverr, e_clock_in, irq_level, nonmaskable_irq_in;
    logic [7:0] ext_rdata_lo, pb_out, pb_oe_n, pe_out, pe_oe_n, pe_pull_en;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    localparam logic [11:0] A_PBD = {`BPP_IDX_PB_DATA, 2'b00};
    localparam logic [11:0] A_PBR = {`BPP_IDX_PB_DIR, 2'b00};
    localparam logic [11:0] A_PED = {`BPP_IDX_PE_DATA, 2'b00};
    localparam logic [11:0] A_PER = {`BPP_IDX_PE_DIR, 2'b00};
    localparam logic [11:0] A_FA = {`BPP_IDX_PE_ASSIGN, 2'b00};
    logic [7:0] oe_t [8] = '{8'hFF, 8'h6F, 8'h6F, 8'hEF, 8'h03, 8'h03, 8'hBF, 8'hFF};
    logic [8:0] fa_t [8] = '{9'h090, 9'h000, 9'h000, 9'h02C, 9'h02C, 9'h02C, 9'h100, 9'h02C};

    bpp_port_mux u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mode, .emulate_port_e, .e_stretch_mode, .pull_up_port_e,
        .ext_bus, .alt_src, .ext_rdata_lo, .e_clock_in, .irq_level, .nonmaskable_irq_in,
        .pb_in(pins[15:8]), .pb_out, .pb_oe_n, .pe_in(pins[7:0]), .pe_out, .pe_oe_n,
        .pe_pull_en);
    bpp_ext_partner u_far (.pclk, .dev_out({pb_out, pe_out}), .dev_oe_n({pb_oe_n, pe_oe_n}),
        .pull_en({8'h00, pe_pull_en}), .ext_en, .ext_val, .pin(pins));

    always #2 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Generous ceiling; the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [32:0] res);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        res = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    // Expected value carries the error flag in bit 8; refused reads return zero data
    task automatic rdc(input string nm, input logic [11:0] a, input logic [8:0] exp);
        logic [32:0] r;
        apb(1'b0, a, 8'h00, r);
        chk(nm, {exp[8], 24'h00_0000, exp[7:0]}, r);
    endtask : rdc

    task automatic rst(input bpp_mode_t m, input logic es);
        @(posedge pclk);
        presetn <= 1'b0;
        mode <= m;
        e_stretch_mode <= es;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst

    task automatic pins_after;
        repeat (2) @(posedge pclk);
    endtask : pins_after

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic sc;
        for (int i = 0; i < 8; i++) begin
            sc = (i == 0 || i == 3 || i == 7);
            rst(bpp_mode_t'(i == 7 ? 3 : i), i == 7);
            chk("pe_oe_n", {25'h0, oe_t[i]}, {25'h0, pe_oe_n});
            rdc("assign", A_FA, fa_t[i]);
            rdc("pe_dir", A_PER, {i == 6, 8'h00});
            rdc("pb_dir", A_PBR, {!sc, 8'h00});
        end
        rst(BPP_NORM_SINGLE, 1'b0);
        wr(A_PBR, 8'hF0);
        wr(A_PBD, 8'hA5);
        ext_en <= 16'h0F03;
        ext_val <= 16'h0C02;
        pins_after();
        chk("pb_pins", 33'hA0F, {21'h0, pb_out[7:4], pb_oe_n});
        rdc("pb_data", A_PBD, 9'h0AC);
        wr(A_PER, 8'hFF);
        rdc("pe_dir", A_PER, 9'h0FC);
        wr(A_PED, 8'h5A);
        pull_up_port_e <= 1'b1;
        pins_after();
        chk("pe_pins", 33'h30302, {9'h0, pe_oe_n, pe_pull_en[7:0] & 8'h0F, 6'h0, irq_level,
            nonmaskable_irq_in});
        // A low enable must hold every output, so the pull-ups stay put
        clk_en <= 1'b0;
        pull_up_port_e <= 1'b0;
        pins_after();
        chk("pe_pull_frozen", 33'h3, {25'h0, pe_pull_en});
        clk_en <= 1'b1;
        pull_up_port_e <= 1'b1;
        rdc("pe_data", A_PED, 9'h05A);
        wr(A_FA, 8'h7F);
        rdc("assign", A_FA, 9'h03F);
        wr(A_FA, 8'h00);
        rdc("assign", A_FA, 9'h03D);
        rdc("unmapped", 12'h030, 9'h100);
        rst(BPP_SPEC_SINGLE, 1'b0);
        wr(A_FA, 8'hFF);
        rdc("assign", A_FA, 9'h03E);
        wr(A_FA, 8'h00);
        rdc("assign", A_FA, 9'h000);
        pins_after();
        chk("eclk", 33'h1, {31'h0, pe_oe_n[4], pe_out[4]});
        wr(A_FA, 8'h14);
        pins_after();
        chk("eclk_off", 33'h3, {31'h0, pe_oe_n[4], pe_oe_n[2]});
        rst(BPP_SPEC_EXP_WIDE, 1'b0);
        wr(A_FA, 8'h00);
        wr(A_FA, 8'h41);
        pins_after();
        chk("pe_alt", 33'h17B, {22'h0, pe_oe_n, pe_out[7:6], pe_out[4]});
        wr(A_FA, 8'h6C);
        pins_after();
        chk("pe_alt", 33'h0ED, {19'h0, pe_oe_n, pe_out[7:2]});
        emulate_port_e <= 1'b1;
        rdc("pe_hidden", A_PED, 9'h100);
        rdc("assign", A_FA, 9'h06C);
        emulate_port_e <= 1'b0;
        ext_bus <= '{addr_lo: 8'h3C, wdata_lo: 8'hC3, addr_phase: 1'b0, data_drive: 1'b1};
        pins_after();
        chk("pb_data_out", 33'hC3, {25'h0, pb_out});
        ext_bus <= '0;
        ext_en <= 16'hFF00;
        ext_val <= 16'h5A00;
        repeat (3) @(posedge pclk);
        chk("pb_read", 33'h5A, {25'h0, ext_rdata_lo});
        for (int m = 1; m < 3; m++) begin
            rst(bpp_mode_t'(m), 1'b0);
            ext_bus <= '{addr_lo: 8'h96, wdata_lo: 8'h69, addr_phase: 1'b1, data_drive: 1'b0};
            wr(A_FA, 8'h08);
            pins_after();
            chk("strobe", {24'h0, m == 1, 8'h96}, {24'h0, pe_oe_n[3], pb_out});
        end
        summarize();
    end
endmodule : tb_bus_port_pin_assignment
